// [dafc_capture_model.sv]
`timescale 1ns/100ps
module dafc_capture_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [dafc_pkg::WORD_W-1:0] word,
    input wire logic flag,
    input wire logic valid,
    output logic [dafc_pkg::WORD_W-1:0] capWord,
    output logic capFlag,
    output int capCount
);
    // Latch each word with its flag in its valid cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            capWord <= 12'h000;
            capFlag <= 1'b0;
            capCount <= 0;
        end else if (valid) begin
            capWord <= word;
            capFlag <= flag;
            capCount <= capCount + 1;
        end
    end
endmodule

// [dafc_converter_top.sv]
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
// Function
// - Four-level strap picks coding and stabilizer
// - One strap setting governs both channels
// - Offset binary: midscale at zero input
// - Two's complement: offset binary, top bit inverted
// - Out of range: flag high, extreme code
// - Stabilizer: sample on rise, ignore fall
// - Stabilizer keeps internal duty at half
// - Relock takes a hundred clock cycles
// - Track while clock low, capture on rise
module dafc_converter_top #(
    parameter int PIPE_LATENCY = dafc_pkg::PIPE_LATENCY,
    parameter int STOP_CYCLES = dafc_pkg::STOP_CYCLES,
    parameter int RELOCK_EDGES = dafc_pkg::RELOCK_EDGES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] modeStrap,
    input wire logic chanASampleClock,
    input wire logic chanBSampleClock,
    input wire logic signed [dafc_pkg::ANA_W-1:0] analogA,
    input wire logic signed [dafc_pkg::ANA_W-1:0] analogB,
    output logic [dafc_pkg::WORD_W-1:0] conversionWordA,
    output logic rangeExceededFlagA,
    output logic wordValidA,
    output logic [dafc_pkg::WORD_W-1:0] conversionWordB,
    output logic rangeExceededFlagB,
    output logic wordValidB,
    output logic trackingA,
    output logic trackingB,
    output logic stabilizerReadyA,
    output logic stabilizerReadyB,
    input wire logic [dafc_pkg::REG_AW-1:0] regAddr,
    input wire logic [dafc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [dafc_pkg::DATA_W-1:0] regRdData,
    output logic irq
);
    localparam int NCH = dafc_pkg::NCH;
    localparam int WORD_W = dafc_pkg::WORD_W;
    localparam int FMT_W = dafc_pkg::FMT_W;
    localparam int PER_W = dafc_pkg::PER_W;
    localparam int EVT_W = dafc_pkg::EVT_W;
    localparam logic [PER_W-1:0] PER_SAT = '1;

    logic [NCH-1:0] sclk, sclkPrev_reg, rise, locked, lockGained, pipeFilled;
    logic [NCH-1:0] internalHigh_reg, internalHigh_next, wordValid_reg, stabRun_reg;
    logic signed [dafc_pkg::ANA_W-1:0] ana [NCH];
    logic [FMT_W-1:0] capFmt [NCH], ofsFmt [NCH], pipeOut [NCH];
    logic [PER_W-1:0] sinceRise_reg [NCH], period_reg [NCH], highCnt_reg [NCH];
    dafc_pkg::dafc_strap_type strap_reg;
    logic twosMode;
    logic stabOn;
    logic [EVT_W-1:0] events, status_reg, mask_reg, clearBits;
    logic [dafc_pkg::DATA_W-1:0] regRdData_reg;
    logic [dafc_pkg::DATA_W-1:0] readMux;

    // Format one held sample: flag bit on top of the 12-bit code
    function automatic logic [FMT_W-1:0] fmt_sample(input logic signed [dafc_pkg::ANA_W-1:0] a,
                                                    input logic twos);
        logic [WORD_W-1:0] w;
        logic o;
        w = dafc_pkg::CODE_MIN;
        o = 1'b0;
        if (a > dafc_pkg::POS_FULL) begin
            o = 1'b1;
            w = dafc_pkg::CODE_MAX;
        end else if (a < dafc_pkg::NEG_FULL) begin
            o = 1'b1;
            w = dafc_pkg::CODE_MIN;
        end else begin
            w = WORD_W'(a + dafc_pkg::MID_OFFSET);
        end
        if (twos) begin
            w = w ^ dafc_pkg::CODE_TOP_BIT;
        end
        return {o, w};
    endfunction

    // Internal high time: half the last period, at least one cycle
    function automatic logic [PER_W-1:0] half_period(input logic [PER_W-1:0] p);
        logic [PER_W-1:0] h;
        h = p >> 1;
        if (h == '0) begin
            h = PER_W'(1);
        end
        return h;
    endfunction

    // Both channel clocks are taken as synchronous to clk
    assign sclk = {chanBSampleClock, chanASampleClock};
    assign ana[0] = analogA;
    assign ana[1] = analogB;

    // Strap level registered every cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_reg <= dafc_pkg::STRAP_GND;
        end else begin
            strap_reg <= dafc_pkg::dafc_strap_type'(modeStrap);
        end
    end

    // Strap decode, one result shared by both channels
    always_comb begin
        case (strap_reg)
            dafc_pkg::STRAP_GND: begin
                twosMode = 1'b0;
                stabOn = 1'b0;
            end
            dafc_pkg::STRAP_THIRD: begin
                twosMode = 1'b0;
                stabOn = 1'b1;
            end
            dafc_pkg::STRAP_TWO_THIRDS: begin
                twosMode = 1'b1;
                stabOn = 1'b1;
            end
            dafc_pkg::STRAP_SUPPLY: begin
                twosMode = 1'b1;
                stabOn = 1'b0;
            end
            default: begin
                twosMode = 1'b0;
                stabOn = 1'b0;
            end
        endcase
    end

    // Rising edge of each sample clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclkPrev_reg <= '0;
        end else begin
            sclkPrev_reg <= sclk;
        end
    end

    assign rise = sclk & ~sclkPrev_reg;

    // Period between rises, saturating on a stopped clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                sinceRise_reg[c] <= '0;
                period_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (rise[c]) begin
                    sinceRise_reg[c] <= PER_W'(1);
                    period_reg[c] <= sinceRise_reg[c];
                end else if (sinceRise_reg[c] != PER_SAT) begin
                    sinceRise_reg[c] <= sinceRise_reg[c] + 1'b1;
                end
            end
        end
    end

    // Internal hold phase: rebuilt from rises with stabilizer, else the pin level
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (stabOn) begin
                internalHigh_next[c] = rise[c] ||
                    (internalHigh_reg[c] && sinceRise_reg[c] < half_period(period_reg[c]));
            end else begin
                internalHigh_next[c] = sclk[c];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            internalHigh_reg <= '0;
        end else begin
            internalHigh_reg <= internalHigh_next;
        end
    end

    // Track while the internal phase is low
    assign trackingA = ~internalHigh_reg[0];
    assign trackingB = ~internalHigh_reg[1];

    // Capture and code the held sample on the rise
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            capFmt[c] = fmt_sample(ana[c], twosMode);
            ofsFmt[c] = fmt_sample(ana[c], 1'b0);
        end
    end

    // Per-channel latency line and stabilizer loop
    for (genvar g = 0; g < NCH; g++) begin : gen_chan
        dafc_sample_pipe #(
            .WIDTH(FMT_W),
            .DEPTH(PIPE_LATENCY)
        ) u_pipe (
            .clk(clk),
            .sys_rst(sys_rst),
            .push(rise[g]),
            .pushData(capFmt[g]),
            .popData(pipeOut[g]),
            .filled(pipeFilled[g])
        );

        dafc_lock_monitor #(
            .STOP_CYCLES(STOP_CYCLES),
            .RELOCK_EDGES(RELOCK_EDGES)
        ) u_lock (
            .clk(clk),
            .sys_rst(sys_rst),
            .enable(stabOn),
            .clockRise(rise[g]),
            .locked(locked[g]),
            .lockGained(lockGained[g])
        );
    end

    // One valid pulse per sample once the line is full
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wordValid_reg <= '0;
        end else begin
            wordValid_reg <= rise & pipeFilled;
        end
    end

    assign conversionWordA = pipeOut[0][WORD_W-1:0];
    assign rangeExceededFlagA = pipeOut[0][WORD_W];
    assign conversionWordB = pipeOut[1][WORD_W-1:0];
    assign rangeExceededFlagB = pipeOut[1][WORD_W];
    assign wordValidA = wordValid_reg[0];
    assign wordValidB = wordValid_reg[1];
    assign stabilizerReadyA = ~stabOn | locked[0];
    assign stabilizerReadyB = ~stabOn | locked[1];

    // Events: range exceeded at capture, lock gained
    always_comb begin
        events = '0;
        events[dafc_pkg::EVT_RANGE_A] = rise[0] & capFmt[0][WORD_W];
        events[dafc_pkg::EVT_RANGE_B] = rise[1] & capFmt[1][WORD_W];
        events[dafc_pkg::EVT_LOCK_A] = lockGained[0];
        events[dafc_pkg::EVT_LOCK_B] = lockGained[1];
    end

    assign clearBits = (regWrEn && regAddr == dafc_pkg::REG_STATUS) ? regWrData[EVT_W-1:0] : '0;

    // Sticky status, write one to clear, a new event wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clearBits) | events;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= '0;
        end else if (regWrEn && regAddr == dafc_pkg::REG_MASK) begin
            mask_reg <= regWrData[EVT_W-1:0];
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Read decode, unmapped reads give zero
    always_comb begin
        readMux = '0;
        case (regAddr)
            dafc_pkg::REG_STATUS: readMux[EVT_W-1:0] = status_reg;
            dafc_pkg::REG_MASK: readMux[EVT_W-1:0] = mask_reg;
            dafc_pkg::REG_CONFIG: begin
                readMux[dafc_pkg::CFG_TWOS] = twosMode;
                readMux[dafc_pkg::CFG_STAB] = stabOn;
                readMux[dafc_pkg::CFG_STRAP_LO +: 2] = strap_reg;
            end
            dafc_pkg::REG_LOCK: begin
                readMux[dafc_pkg::LOCK_LOCKED_LO +: NCH] = locked;
                readMux[dafc_pkg::LOCK_READY_LO +: NCH] = ~{NCH{stabOn}} | locked;
            end
            default: readMux = '0;
        endcase
    end

    // Read data stand for one cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData_reg <= '0;
        end else begin
            regRdData_reg <= regRdEn ? readMux : '0;
        end
    end

    assign regRdData = regRdData_reg;

    // Checker helpers: high run since the last rise, stabilizer-started runs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                highCnt_reg[c] <= '0;
            end
            stabRun_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                highCnt_reg[c] <= (internalHigh_reg[c] && !rise[c]) ? highCnt_reg[c] + 1'b1 : '0;
            end
            stabRun_reg <= (rise & {NCH{stabOn}}) | (stabRun_reg & ~rise & {NCH{stabOn}});
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_strap_decode:
        assert property (($past(modeStrap) == 2'b01 || $past(modeStrap) == 2'b10) == stabOn
            && ($past(modeStrap) >= 2'b10) == twosMode)
        else $error("strap decode wrong");
    a_same_mode:
        assert property ((capFmt[0][WORD_W-1] ^ ofsFmt[0][WORD_W-1]) == (capFmt[1][WORD_W-1] ^ ofsFmt[1][WORD_W-1]))
        else $error("channels disagree on output coding");
    a_offset_mid:
        assert property ((ana[0] == 16'sh0000 && !twosMode) |-> capFmt[0] == 13'h0800)
        else $error("zero input not midscale in offset binary");
    a_twos_invert:
        assert property (twosMode |-> capFmt[1][WORD_W-1:0] == (ofsFmt[1][WORD_W-1:0] ^ dafc_pkg::CODE_TOP_BIT))
        else $error("two's complement not top-bit inverse");
    a_range_clamp:
        assert property ((rise[0] && ana[0] > dafc_pkg::POS_FULL && !twosMode) |-> capFmt[0] == 13'h1FFF)
        else $error("over range not clamped with flag");
    a_range_quiet:
        assert property ((ana[1] <= dafc_pkg::POS_FULL && ana[1] >= dafc_pkg::NEG_FULL) |-> !capFmt[1][WORD_W])
        else $error("flag set for in-range sample");
    a_rise_only:
        assert property ((stabOn && $past(stabOn) && $rose(internalHigh_reg[0])) |-> $past(rise[0]))
        else $error("internal phase rose without a clock rise");
    a_half_duty:
        assert property ((stabOn && stabRun_reg[0] && $fell(internalHigh_reg[0]))
            |-> highCnt_reg[0] == half_period(period_reg[0]))
        else $error("internal high time not half period");
    a_track_low:
        assert property ((!stabOn && !$past(stabOn)) |-> trackingA == !$past(sclk[0]))
        else $error("tracking does not follow low clock");
    a_word_rate:
        assert property ((rise[0] && pipeFilled[0]) |=> (wordValidA ##1 !wordValidA))
        else $error("valid not a single pulse per sample");
    a_sticky_set:
        assert property (events[dafc_pkg::EVT_RANGE_A] |=> status_reg[dafc_pkg::EVT_RANGE_A])
        else $error("range event lost");
    c_overflow: cover property (rise[0] && capFmt[0][WORD_W]);
    c_lock_gained: cover property (lockGained[1]);
    c_twos_word: cover property (twosMode && wordValidB);
    c_irq_raise: cover property ($rose(irq));
endmodule

// [dafc_lock_monitor.sv]
`timescale 1ns/100ps
module dafc_lock_monitor #(
    parameter int STOP_CYCLES = dafc_pkg::STOP_CYCLES,
    parameter int RELOCK_EDGES = dafc_pkg::RELOCK_EDGES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic clockRise,
    output logic locked,
    output logic lockGained
);
    localparam int IDLE_W = $clog2(STOP_CYCLES + 1);
    localparam int EDGE_W = $clog2(RELOCK_EDGES + 1);
    localparam logic [IDLE_W-1:0] STOP_LIM = IDLE_W'(STOP_CYCLES);
    localparam logic [EDGE_W-1:0] EDGE_LAST = EDGE_W'(RELOCK_EDGES - 1);

    dafc_pkg::dafc_lock_type state_reg, state_next;
    logic [IDLE_W-1:0] idle_reg;
    logic [EDGE_W-1:0] edges_reg;
    logic gained_reg;
    logic stopped;

    assign stopped = (idle_reg >= STOP_LIM);

    // Time since the last sample clock rise
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_reg <= '0;
        end else if (clockRise) begin
            idle_reg <= '0;
        end else if (!stopped) begin
            idle_reg <= idle_reg + 1'b1;
        end
    end

    // Loop state: a stopped clock drops lock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dafc_pkg::LK_STOPPED: begin
                if (enable && clockRise) begin
                    state_next = dafc_pkg::LK_ACQUIRE;
                end
            end
            dafc_pkg::LK_ACQUIRE: begin
                if (!enable || stopped) begin
                    state_next = dafc_pkg::LK_STOPPED;
                end else if (clockRise && edges_reg == EDGE_LAST) begin
                    state_next = dafc_pkg::LK_LOCKED;
                end
            end
            dafc_pkg::LK_LOCKED: begin
                if (!enable || stopped) begin
                    state_next = dafc_pkg::LK_STOPPED;
                end
            end
            default: begin
                state_next = dafc_pkg::LK_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= dafc_pkg::LK_STOPPED;
        end else begin
            state_reg <= state_next;
        end
    end

    // Rising edges seen while acquiring, first one included
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            edges_reg <= '0;
        end else if (state_reg != dafc_pkg::LK_ACQUIRE) begin
            edges_reg <= (state_next == dafc_pkg::LK_ACQUIRE) ? EDGE_W'(1) : '0;
        end else if (clockRise) begin
            edges_reg <= edges_reg + 1'b1;
        end
    end

    // Lock gained pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gained_reg <= 1'b0;
        end else begin
            gained_reg <= (state_next == dafc_pkg::LK_LOCKED) && (state_reg != dafc_pkg::LK_LOCKED);
        end
    end

    assign locked = (state_reg == dafc_pkg::LK_LOCKED);
    assign lockGained = gained_reg;

    a_relock_count:
        assert property (@(posedge clk) disable iff (sys_rst)
            (state_reg == dafc_pkg::LK_ACQUIRE && enable && !stopped && clockRise && edges_reg == EDGE_LAST)
            |=> (locked && lockGained))
        else $error("loop did not lock on the last relock edge");

    a_no_early_lock:
        assert property (@(posedge clk) disable iff (sys_rst)
            $rose(locked) |-> ($past(edges_reg) == EDGE_LAST && $past(clockRise)))
        else $error("loop locked before the relock edge count");
endmodule

// [dafc_pkg.sv]
package dafc_pkg;

    // Channel count and word layout
    localparam int NCH = 2;
    localparam int WORD_W = 12;
    localparam int ANA_W = 16;
    localparam int FMT_W = WORD_W + 1;

    // Output codes, offset binary view
    localparam logic [WORD_W-1:0] CODE_MAX = 12'hFFF;
    localparam logic [WORD_W-1:0] CODE_MIN = 12'h000;
    localparam logic [WORD_W-1:0] CODE_TOP_BIT = 12'h800;

    // Sample limits in steps of one code
    localparam logic signed [ANA_W-1:0] POS_FULL = 16'sh07FF;
    localparam logic signed [ANA_W-1:0] NEG_FULL = 16'shF800;
    localparam logic signed [ANA_W-1:0] MID_OFFSET = 16'sh0800;

    // Four-level format strap
    typedef enum logic [1:0] {
        STRAP_GND = 2'b00,
        STRAP_THIRD = 2'b01,
        STRAP_TWO_THIRDS = 2'b10,
        STRAP_SUPPLY = 2'b11
    } dafc_strap_type;

    // Stabilizer loop states
    typedef enum logic [1:0] {
        LK_STOPPED = 2'b00,
        LK_ACQUIRE = 2'b01,
        LK_LOCKED = 2'b10
    } dafc_lock_type;

    // Register port
    localparam int REG_AW = 4;
    localparam int DATA_W = 32;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h0;
    localparam logic [REG_AW-1:0] REG_MASK = 4'h4;
    localparam logic [REG_AW-1:0] REG_CONFIG = 4'h8;
    localparam logic [REG_AW-1:0] REG_LOCK = 4'hC;

    // Event bits of status and mask
    localparam int EVT_W = 4;
    localparam int EVT_RANGE_A = 0;
    localparam int EVT_RANGE_B = 1;
    localparam int EVT_LOCK_A = 2;
    localparam int EVT_LOCK_B = 3;

    // Config and lock register fields
    localparam int CFG_TWOS = 0;
    localparam int CFG_STAB = 1;
    localparam int CFG_STRAP_LO = 2;
    localparam int LOCK_LOCKED_LO = 0;
    localparam int LOCK_READY_LO = 2;

    // Timing
    localparam int CLK_MHZ = 125;
    localparam int STOP_NS = 1000;
    localparam int STOP_CYCLES = (STOP_NS * CLK_MHZ + 999) / 1000;
    localparam int RELOCK_EDGES = 100;
    localparam int PER_W = 16;
    localparam int PIPE_LATENCY = 5;

endpackage

// [dafc_sample_pipe.sv]
`timescale 1ns/100ps
module dafc_sample_pipe #(
    parameter int WIDTH = dafc_pkg::FMT_W,
    parameter int DEPTH = dafc_pkg::PIPE_LATENCY
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    output logic [WIDTH-1:0] popData,
    output logic filled
);
    localparam int FILL_W = $clog2(DEPTH + 1);
    localparam logic [FILL_W-1:0] FILL_LIM = FILL_W'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] popData_reg;
    logic [FILL_W-1:0] fill_reg;

    // Shift one stage per sample
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (push) begin
            mem_reg[0] <= pushData;
            for (int i = 1; i < DEPTH; i++) begin
                mem_reg[i] <= mem_reg[i-1];
            end
        end
    end

    // Registered read of the oldest stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            popData_reg <= '0;
        end else if (push) begin
            popData_reg <= mem_reg[DEPTH-1];
        end
    end

    // Count stages holding real samples
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_reg <= '0;
        end else if (push && fill_reg != FILL_LIM) begin
            fill_reg <= fill_reg + 1'b1;
        end
    end

    assign popData = popData_reg;
    assign filled = (fill_reg == FILL_LIM);
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic clk, sysRst, sclk, wrEn, rdEn, flA, flB, vaA, vaB, trA, trB, rdyA, rdyB, irq, cFl, cFlB;
    logic [1:0] strap;
    logic signed [15:0] anaA, anaB;
    logic [11:0] wA, wB, cW, cWB;
    logic [3:0] adr;
    logic [31:0] wd, rdData, rv;
    int cCnt, cCntB, n_errors, compares, cyc;
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    dafc_converter_top #(.PIPE_LATENCY(1), .STOP_CYCLES(20), .RELOCK_EDGES(4)) uut (.clk(clk), .sys_rst(sysRst),
        .modeStrap(strap), .chanASampleClock(sclk), .chanBSampleClock(sclk), .analogA(anaA), .analogB(anaB),
        .conversionWordA(wA), .rangeExceededFlagA(flA), .wordValidA(vaA), .conversionWordB(wB),
        .rangeExceededFlagB(flB), .wordValidB(vaB), .trackingA(trA), .trackingB(trB), .stabilizerReadyA(rdyA),
        .stabilizerReadyB(rdyB), .regAddr(adr), .regWrData(wd), .regWrEn(wrEn), .regRdEn(rdEn),
        .regRdData(rdData), .irq(irq));
    dafc_capture_model cap (.clk(clk), .sys_rst(sysRst), .word(wA), .flag(flA), .valid(vaA),
        .capWord(cW), .capFlag(cFl), .capCount(cCnt));
    dafc_capture_model capB (.clk(clk), .sys_rst(sysRst), .word(wB), .flag(flB), .valid(vaB),
        .capWord(cWB), .capFlag(cFlB), .capCount(cCntB));
    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        adr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 d = rdData;
        @(posedge clk);
    endtask
    // Shared channel clock, even duty, within rate limits
    task automatic pulse();
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
        chk("trackA", trA, 1'b0);
        chk("trackB", trB, 1'b0);
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [12:0] code(input int v, input logic twos);
        logic [11:0] w;
        w = (v > 2047) ? 12'hFFF : (v < -2048) ? 12'h000 : 12'(v + 2048);
        return {(v > 2047 || v < -2048), w ^ {twos, 11'h000}};
    endfunction
    task automatic conv(input int a, input int b, input logic twos);
        int n0, n1;
        n0 = cCnt;
        n1 = cCntB;
        anaA <= 16'(a);
        anaB <= 16'(b);
        pulse();
        pulse();
        chk("wordA", {cFl, cW}, code(a, twos));
        chk("wordB", {flB, wB}, code(b, twos));
        chk("capB", {cFlB, cWB}, code(b, twos));
        chk("count", cCnt - n0, 2);
        chk("countB", cCntB - n1, 2);
    endtask
    task automatic t_format();
        int vals[6] = '{0, 1, 2047, -2048, 3000, -3000};
        for (int s = 0; s < 4; s++) begin
            strap <= 2'(s);
            repeat (3) @(posedge clk);
            rd(4'h8, rv);
            chk("config", rv, {28'h0, 2'(s), 1'(s == 1 || s == 2), 1'(s >= 2)});
            foreach (vals[i]) conv(vals[i], -vals[i] - 1, s >= 2);
        end
    endtask
    task automatic t_irq();
        strap <= 2'b00;
        repeat (3) @(posedge clk);
        wr(4'h0, 32'hF);
        wr(4'h4, 32'h0);
        conv(3000, 0, 1'b0);
        rd(4'h0, rv);
        chk("status", rv, 32'h1);
        chk("irqMasked", irq, 1'b0);
        wr(4'h4, 32'h1);
        chk("irqOn", irq, 1'b1);
        wr(4'h0, 32'h1);
        chk("irqOff", irq, 1'b0);
        rd(4'h1, rv);
        chk("unmapped", rv, 32'h0);
    endtask
    task automatic t_lock();
        strap <= 2'b01;
        repeat (3) @(posedge clk);
        repeat (3) pulse();
        chk("rdyEarly", rdyA, 1'b0);
        pulse();
        chk("rdyA", rdyA, 1'b1);
        chk("rdyB", rdyB, 1'b1);
        rd(4'hC, rv);
        chk("lockReg", rv, 32'hF);
        rd(4'h0, rv);
        chk("lockEvt", rv[3:2], 2'b11);
        repeat (30) @(posedge clk);
        chk("rdyStop", rdyA, 1'b0);
        repeat (4) pulse();
        chk("relock", rdyA, 1'b1);
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    // Reset, then the scenarios in turn
    initial begin
        sysRst = 1'b1;
        sclk = 1'b0;
        strap = 2'b00;
        anaA = 16'h0000;
        anaB = 16'h0000;
        adr = 4'h0;
        wd = 32'h0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        n_errors = 0;
        compares = 0;
        cyc = 0;
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        pulse();
        t_format();
        t_irq();
        t_lock();
        end_of_test();
    end
endmodule
